// >>> arfb_pkg.sv
// shared constants for the converter result formatter and bias control
package arfb_pkg;
  // register byte offsets
  localparam logic [11:0] ARFB_OFF_RESULT_HIGH = 12'h000;
  localparam logic [11:0] ARFB_OFF_RESULT_LOW = 12'h004;
  localparam logic [11:0] ARFB_OFF_CONFIG = 12'h008;
  localparam logic [11:0] ARFB_OFF_CONTROL = 12'h00C;
  localparam logic [11:0] ARFB_OFF_STATUS = 12'h010;
  localparam logic [11:0] ARFB_OFF_RAW_SAMPLE = 12'h014;
  // config field positions
  localparam int ARFB_CFG_OSR_LSB = 0;
  localparam int ARFB_CFG_NELC_LSB = 3;
  localparam int ARFB_CFG_CBIAS_LSB = 5;
  localparam int ARFB_CFG_ABIAS_LSB = 7;
  localparam int ARFB_CFG_CONV_EN = 9;
  localparam int ARFB_CFG_AMP_EN = 10;
  // control bits
  localparam int ARFB_CTL_START = 0;
  localparam int ARFB_CTL_PRESET = 1;
  // reset values: full bias, both stages enabled, shortest oversampling and averaging (codes zero)
  localparam logic [10:0] ARFB_CFG_RESET = 11'h7E0;
  localparam logic [15:0] ARFB_RESULT_RESET = 16'h0000;
  // result limits
  localparam logic [15:0] ARFB_POS_FULL = 16'h7FFF;
  localparam logic [15:0] ARFB_NEG_FULL = 16'h8000;
  localparam int ARFB_RES_MIN = 6;
  localparam int ARFB_RES_MAX = 16;
  // bias codes
  localparam logic [1:0] ARFB_BIAS_FULL = 2'h3;
  // cycles from a start to result capture
  localparam int ARFB_CONV_CYCLES = 4;
  typedef enum logic [2:0] {
    ARFB_IDLE = 3'b001,
    ARFB_BUSY = 3'b010,
    ARFB_DONE = 3'b100
  } arfb_state_t;
endpackage

// >>> arfb_ctrl.sv
// result formatting, resolution masking and bias control behind an apb slave
//
// Contract
// - results are signed 16-bit two's complement, zero input gives zero; below sixteen bits the code returns the forced bit alone for zero
// - overrange clamps to 0x7FFF, underrange clamps to 0x8000; below sixteen bits the code forces the low field after the clamp
// - below sixteen bits resolution, low 16-n result bits are forced
// - forced field is a one followed by zeros, ten bits down to none
// - result readable as high byte and low byte registers
// - converter bias code selects quarter to full current, 62.5 to 500 kHz
// - amplifier bias code selects the same quarter steps and ceilings
// - converter and amplifier stages can be switched off when idle
// - resolution follows oversampling and averaging, six to sixteen bits
// - oversampling code sets 8 to 1024 integration cycles per pass
// - elementary conversion code sets 1, 2, 4 or 8 averaged passes
// - start or preset start bit begins a new conversion sequence; the code ignores it while busy or with the converter disabled
//
// Added by the designer: the register addresses and register access over APB.
module arfb_ctrl import arfb_pkg::*; #(
  parameter int RAW_W = 18
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter core
  input wire logic signed [RAW_W-1:0] raw_sample,
  input wire logic raw_valid,
  // analog controls
  output logic [1:0] converter_bias_sel,
  output logic [1:0] amplifier_bias_sel,
  output logic converter_enable,
  output logic amplifier_enable,
  output logic [2:0] oversample_sel,
  output logic [1:0] elem_conv_count_sel,
  output logic [10:0] oversampling_ratio,
  output logic [3:0] elem_conv_count,
  output logic [4:0] resolution,
  output logic conv_start,
  output logic conv_busy
);

  ////////////////////////////////////////////////////////////////////
  logic [10:0] cfg;
  logic [15:0] result;
  logic [RAW_W-1:0] raw_seen;
  logic [2:0] conv_cnt;
  arfb_state_t state;
  logic wr_en;
  logic rd_hit;
  logic start_req;
  logic [15:0] next_result;
  logic [15:0] force_mask;
  logic [15:0] force_bit;
  logic [4:0] drop;
  // configuration fields
  logic cfg_wr;
  logic [2:0] osr_field;
  logic [1:0] nelc_field;
  logic [1:0] cbias_field;
  logic [1:0] abias_field;
  logic conv_on;
  logic amp_on;
  logic capture;

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign start_req = wr_en && (paddr == ARFB_OFF_CONTROL) &&
    (pwdata[ARFB_CTL_START] || pwdata[ARFB_CTL_PRESET]);

  ////////////////////////////////////////////////////////////////////
  // configuration fields, one register per field
  assign cfg_wr = wr_en && (paddr == ARFB_OFF_CONFIG);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osr_field <= ARFB_CFG_RESET[ARFB_CFG_OSR_LSB +: 3];
    end else if (cfg_wr) begin
      osr_field <= pwdata[ARFB_CFG_OSR_LSB +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nelc_field <= ARFB_CFG_RESET[ARFB_CFG_NELC_LSB +: 2];
    end else if (cfg_wr) begin
      nelc_field <= pwdata[ARFB_CFG_NELC_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cbias_field <= ARFB_CFG_RESET[ARFB_CFG_CBIAS_LSB +: 2];
    end else if (cfg_wr) begin
      cbias_field <= pwdata[ARFB_CFG_CBIAS_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abias_field <= ARFB_CFG_RESET[ARFB_CFG_ABIAS_LSB +: 2];
    end else if (cfg_wr) begin
      abias_field <= pwdata[ARFB_CFG_ABIAS_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_on <= ARFB_CFG_RESET[ARFB_CFG_CONV_EN];
    end else if (cfg_wr) begin
      conv_on <= pwdata[ARFB_CFG_CONV_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_on <= ARFB_CFG_RESET[ARFB_CFG_AMP_EN];
    end else if (cfg_wr) begin
      amp_on <= pwdata[ARFB_CFG_AMP_EN];
    end
  end

  // readback image of the configuration word
  assign cfg = {amp_on, conv_on, abias_field, cbias_field, nelc_field, osr_field};

  assign oversample_sel = osr_field;
  assign elem_conv_count_sel = nelc_field;
  assign converter_bias_sel = cbias_field;
  assign amplifier_bias_sel = abias_field;
  // disabling stops the core; rate ceilings are software's concern
  assign converter_enable = conv_on;
  assign amplifier_enable = amp_on;
  assign oversampling_ratio = 11'h008 << oversample_sel;
  assign elem_conv_count = 4'h1 << elem_conv_count_sel;

  ////////////////////////////////////////////////////////////////////
  // resolution per oversampling and averaging code, capped by the result width
  always_comb begin
    unique case ({oversample_sel, elem_conv_count_sel})
      5'h00: resolution = 5'h06;
      5'h01: resolution = 5'h07;
      5'h02: resolution = 5'h08;
      5'h03: resolution = 5'h09;
      5'h04: resolution = 5'h08;
      5'h05: resolution = 5'h09;
      5'h06: resolution = 5'h0A;
      5'h07: resolution = 5'h0B;
      5'h08: resolution = 5'h0A;
      5'h09: resolution = 5'h0B;
      5'h0A: resolution = 5'h0C;
      5'h0B: resolution = 5'h0D;
      5'h0C: resolution = 5'h0C;
      5'h0D: resolution = 5'h0D;
      5'h0E: resolution = 5'h0E;
      5'h0F: resolution = 5'h0F;
      5'h10: resolution = 5'h0E;
      5'h11: resolution = 5'h0F;
      5'h12: resolution = 5'h10;
      5'h13: resolution = 5'h10;
      5'h14: resolution = 5'h10;
      5'h15: resolution = 5'h10;
      5'h16: resolution = 5'h10;
      5'h17: resolution = 5'h10;
      5'h18: resolution = 5'h10;
      5'h19: resolution = 5'h10;
      5'h1A: resolution = 5'h10;
      5'h1B: resolution = 5'h10;
      5'h1C: resolution = 5'h10;
      5'h1D: resolution = 5'h10;
      5'h1E: resolution = 5'h10;
      5'h1F: resolution = 5'h10;
    endcase
  end

  // forced low field: a one on top, zeros below, nothing at full resolution
  assign drop = 5'(ARFB_RES_MAX) - resolution;
  assign force_mask = 16'((17'h0_0001 << drop) - 17'h0_0001);
  always_comb begin
    unique case (drop)
      5'h00: force_bit = 16'h0000;
      5'h01: force_bit = 16'h0001;
      5'h02: force_bit = 16'h0002;
      5'h03: force_bit = 16'h0004;
      5'h04: force_bit = 16'h0008;
      5'h05: force_bit = 16'h0010;
      5'h06: force_bit = 16'h0020;
      5'h07: force_bit = 16'h0040;
      5'h08: force_bit = 16'h0080;
      5'h09: force_bit = 16'h0100;
      5'h0A: force_bit = 16'h0200;
      default: force_bit = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // saturation and low-bit forcing
  always_comb begin
    logic [15:0] sat;
    sat = 16'h0000;
    // the raw word is wider than the result, so both limits can be crossed
    if (raw_sample > RAW_W'(signed'(16'h7FFF))) begin
      sat = ARFB_POS_FULL;
    end else if (raw_sample < RAW_W'(signed'(ARFB_NEG_FULL))) begin
      sat = ARFB_NEG_FULL;
    end else begin
      sat = raw_sample[15:0];
    end
    next_result = (sat & ~force_mask) | force_bit;
  end

  ////////////////////////////////////////////////////////////////////
  // conversion sequencer
  // the core may report sooner; a fixed floor keeps results ordered
  assign capture = (state == ARFB_BUSY) && raw_valid &&
    (conv_cnt >= 3'(ARFB_CONV_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ARFB_IDLE;
    end else begin
      unique case (state)
        ARFB_IDLE: begin
          if (start_req && converter_enable) begin
            state <= ARFB_BUSY;
          end
        end
        ARFB_BUSY: begin
          if (capture) begin
            state <= ARFB_DONE;
          end
        end
        ARFB_DONE: begin
          if (start_req && converter_enable) begin
            state <= ARFB_BUSY;
          end else begin
            state <= ARFB_IDLE;
          end
        end
        default: begin
          state <= ARFB_IDLE;
        end
      endcase
    end
  end

  // floor counter for the minimum busy time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_cnt <= 3'h0;
    end else if (state != ARFB_BUSY) begin
      conv_cnt <= 3'h0;
    end else if (conv_cnt < 3'(ARFB_CONV_CYCLES - 1)) begin
      conv_cnt <= conv_cnt + 3'h1;
    end
  end

  assign conv_start = start_req && converter_enable && (state != ARFB_BUSY);
  assign conv_busy = (state == ARFB_BUSY);

  // result holds until the next capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= ARFB_RESULT_RESET;
    end else if (capture) begin
      result <= next_result;
    end
  end

  // last raw sample, kept for diagnosis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_seen <= '0;
    end else if (capture) begin
      raw_seen <= raw_sample;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // apb read mux
  always_comb begin
    rd_hit = 1'b1;
    prdata = 32'h0000_0000;
    unique case (paddr)
      ARFB_OFF_RESULT_HIGH: prdata[7:0] = result[15:8];
      ARFB_OFF_RESULT_LOW: prdata[7:0] = result[7:0];
      ARFB_OFF_CONFIG: prdata[10:0] = cfg;
      ARFB_OFF_CONTROL: prdata = 32'h0000_0000;
      ARFB_OFF_STATUS: prdata[5:0] = {conv_busy, resolution};
      ARFB_OFF_RAW_SAMPLE: prdata[RAW_W-1:0] = raw_seen;
      default: rd_hit = 1'b0;
    endcase
  end

  // unmapped offsets answer with an error; read-only ones drop writes
  assign pslverr = psel && penable && !rd_hit;

endmodule

// >>> arfb_ctrl_assertions.sv
// assertion checker for the converter result formatter
module arfb_ctrl_chk import arfb_pkg::*; (
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [1:0] converter_bias_sel, amplifier_bias_sel, elem_conv_count_sel,
  input wire logic converter_enable, amplifier_enable, conv_start, conv_busy,
  input wire logic [2:0] oversample_sel,
  input wire logic [10:0] oversampling_ratio,
  input wire logic [3:0] elem_conv_count,
  input wire logic [4:0] resolution
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  int n_res;
  assign acc = psel && penable;
  assign n_res = 6 + 2 * oversample_sel + elem_conv_count_sel;
  chk_full_bias: assert property ($rose(presetn) |-> converter_bias_sel == 2'h3
    && amplifier_bias_sel == 2'h3) else $error("bias not full after reset");
  chk_bias_store: assert property (acc && pwrite && paddr == ARFB_OFF_CONFIG |=>
    {amplifier_enable, converter_enable, amplifier_bias_sel, converter_bias_sel}
    == $past(pwdata[10:5])) else $error("bias or enable not stored");
  chk_osr_ratio: assert property (oversampling_ratio == 11'(11'h8 << oversample_sel))
    else $error("ratio mismatch");
  chk_elem_count: assert property (elem_conv_count == 4'(4'h1 << elem_conv_count_sel))
    else $error("elem count mismatch");
  chk_res_span: assert property (resolution == 5'(n_res > 16 ? 16 : n_res))
    else $error("resolution mismatch");
  chk_start_busy: assert property (conv_start |=> conv_busy) else $error("start lost");
  chk_stop_start: assert property (!converter_enable |-> !conv_start)
    else $error("start while off");
  chk_busy_hold: assert property ($rose(conv_busy) |-> conv_busy [*4])
    else $error("busy too short");
  chk_unmapped: assert property (acc && paddr > 12'h014 |-> pslverr) else $error("no err");
endmodule
bind arfb_ctrl arfb_ctrl_chk i_chk (.*);

// >>> arfb_core_model.sv
// converter core model: result valid once the lag has run out
module arfb_core_model (
  input wire logic pclk,
  input wire logic conv_busy,
  input wire logic [17:0] value,
  input wire logic [3:0] lag,
  output logic [17:0] raw_sample,
  output logic raw_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt = 4'h0;
  always_ff @(posedge pclk) cnt <= conv_busy ? cnt + 4'h1 : 4'h0;
  assign raw_valid = conv_busy && cnt >= lag;
  // stale data shows inverted so an early capture is seen
  assign raw_sample = raw_valid ? value : ~value;
endmodule

// >>> arfb_ctrl_tb.sv
// testbench for the converter result formatter and bias control
module arfb_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import arfb_pkg::*;
  logic pclk = 0, presetn, psel, penable, pwrite, pready, pslverr, raw_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [17:0] val, raw_sample;
  logic [3:0] lag;
  logic [1:0] cb, ab;
  logic ce, ae, cs, cbusy, err;
  int bad_count = 0, total_checks = 0;
  arfb_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .raw_sample(raw_sample), .raw_valid(raw_valid),
    .converter_bias_sel(cb), .amplifier_bias_sel(ab), .converter_enable(ce),
    .amplifier_enable(ae), .oversample_sel(), .elem_conv_count_sel(),
    .oversampling_ratio(), .elem_conv_count(), .resolution(), .conv_start(cs),
    .conv_busy(cbusy));
  arfb_core_model i_core (.pclk(pclk), .conv_busy(cbusy), .value(val), .lag(lag),
    .raw_sample(raw_sample), .raw_valid(raw_valid));
  initial forever #20 pclk = ~pclk;
  //////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) begin bad_count++; complete_run; end
    psel <= 0; penable <= 0;
  endtask
  function automatic logic [15:0] expv(int o, int e, logic signed [17:0] v);
    logic [15:0] r;
    int n;
    r = v > 32767 ? 16'h7FFF : v < -32768 ? 16'h8000 : v[15:0];
    n = 6 + 2 * o + e;
    if (n < 16) begin r = r >> (16 - n) << (16 - n); r[15 - n] = 1'b1; end
    return r;
  endfunction
  task automatic conv(int o, int e, logic [17:0] v, logic [3:0] l);
    int n;
    logic [15:0] x;
    n = 0; val = v; lag = l; x = expv(o, e, v);
    apb(1, ARFB_OFF_CONFIG, 32'h07E0 | o | e << 3);
    apb(1, ARFB_OFF_CONTROL, 32'h1);
    @(posedge pclk);
    while (cbusy !== 1'b0 && n < 50) begin @(posedge pclk); n++; end
    if (n >= 50) begin bad_count++; complete_run; end
    apb(0, ARFB_OFF_RESULT_HIGH, 0); chk("high", x[15:8], rd);
    apb(0, ARFB_OFF_RESULT_LOW, 0); chk("low", x[7:0], rd);
    apb(0, ARFB_OFF_STATUS, 0);
    chk("status", 6 + 2 * o + e > 16 ? 16 : 6 + 2 * o + e, rd);
  endtask
  task automatic mid_reset;
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, ARFB_OFF_CONFIG, 0); chk("cfg after reset", 32'h07E0, rd);
    apb(0, ARFB_OFF_RESULT_LOW, 0); chk("result after reset", 0, rd);
  endtask
  task automatic reset_vals;
    apb(0, ARFB_OFF_CONFIG, 0); chk("config", 32'h07E0, rd);
    apb(0, 12'h018, 0); chk("unmapped", 1, err);
  endtask
  task automatic bias_modes;
    for (int c = 0; c < 4; c++) begin
      apb(1, ARFB_OFF_CONFIG, c << 5 | c << 7);
      @(negedge pclk);
      chk("cbias", c, cb); chk("abias", c, ab); chk("ens", 0, {ce, ae});
    end
    apb(1, ARFB_OFF_CONTROL, 32'h2); @(posedge pclk); chk("off busy", 0, cbusy);
  endtask
  task automatic results;
    conv(5, 0, 0, 0); conv(5, 0, 18'h3FFFF, 9); conv(5, 0, 18'h08000, 0);
    conv(5, 0, 18'h37FFF, 2); conv(0, 0, 18'h01234, 0); conv(3, 3, 18'h01234, 5);
    conv(4, 0, 18'h20000, 0); conv(2, 1, 18'h00ABC, 1);
  endtask
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0; val = 0; lag = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    reset_vals; bias_modes; results; mid_reset;
    complete_run;
  end
endmodule
